//--- core/result_packer.sv
`default_nettype none
// lays a finished 10-bit code out over the two result bytes
module result_packer
(
    input wire logic [9:0] code,
    input wire logic left_align_select,
    input wire logic differential,
    output logic [7:0] high_byte,
    output logic [7:0] low_byte
);
    import sar_adc_pkg::*;

    logic [9:0] word; // code as read out, offset-binary flipped to two's complement when differential
    logic [15:0] packed_word;

    // the array hands back offset binary; flipping the top bit makes it signed
    assign word = differential ? (code ^ CODE_MSB_ONLY) : code;

    always_comb
    begin
        if (left_align_select)
            packed_word = {word, 6'h00};
        else if (differential)
            packed_word = {{6{word[9]}}, word};
        else
            packed_word = {6'h00, word};
    end

    assign high_byte = packed_word[15:8];
    assign low_byte = packed_word[7:0];
endmodule
`default_nettype wire

//--- core/sar_adc_pkg.sv
`default_nettype none
package sar_adc_pkg;
    // register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] CONTROL_ADDR = 4'h0;
    localparam logic [3:0] CONFIG_ADDR = 4'h1;
    localparam logic [3:0] RESULT_HIGH_ADDR = 4'h2;
    localparam logic [3:0] RESULT_LOW_ADDR = 4'h3;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // converter_control_reg field positions
    localparam int ON_BIT = 7;
    localparam int TRACK_MODE_BIT = 6;
    localparam int DONE_BIT = 5;
    localparam int BUSY_BIT = 4;
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 3;
    // converter_config_reg field positions
    localparam int DIV_LSB = 3;
    localparam int DIV_W = 5;
    localparam int LEFT_BIT = 2;
    localparam int DIFF_BIT = 0;
    // values after reset
    localparam logic [4:0] DIV_RESET = 5'h1F;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // code geometry
    localparam int CODE_W = 10;
    localparam logic [9:0] CODE_MSB_ONLY = 10'h200;
    localparam logic [3:0] CODE_TOP_INDEX = 4'h9;
    // low-power tracking length in conversion-clock ticks
    localparam logic [1:0] TRACK_TICKS = 2'h3;
    // throughput ceiling turned into a least spacing between starts
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int MAX_RATE_KSPS = 500;
    localparam int MIN_START_SPACING_NS = 1000000 / MAX_RATE_KSPS;
    localparam int SPACING_CYCLES_INT = (MIN_START_SPACING_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [7:0] SPACING_LAST = 8'(SPACING_CYCLES_INT - 1);
    // start-of-conversion sources
    typedef enum logic [2:0] {
        SRC_SOFTWARE = 3'h0,
        SRC_TIMER0 = 3'h1,
        SRC_TIMER2 = 3'h2,
        SRC_TIMER1 = 3'h3,
        SRC_EXT_PIN = 3'h4,
        SRC_TIMER3 = 3'h5,
        SRC_TIMER4 = 3'h6,
        SRC_TIMER5 = 3'h7
    } start_source_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRACK,
        ST_CONVERT
    } seq_state_t;
endpackage
`default_nettype wire

//--- core/sar_adc_sequencer.sv
`default_nettype none
// Behaviour
// - converter runs only while enable bit set
// - result bytes loaded at every conversion end
// - single-ended code unsigned, right or left
// - unused single-ended result bits read zero
// - differential right-justified sign-extends high byte
// - differential left-justified low bits read zero
// - sar clock divided from system clock
// - three-bit field picks one of eight triggers
// - software writes busy one to start
// - busy high whole conversion, then cleared
// - busy falling edge sets done, interrupt
// - timers 2-5 use low or high overflow
// - default mode tracks except while converting
// - low-power mode tracks three sar ticks first
// - pin trigger tracks low, converts on rise
// - tracking off during standby or sleep
// - justify bit zero right, one left
// - five-bit divider, period times value plus one
module sar_adc_sequencer
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [sar_adc_pkg::ADDR_W-1:0] address,
    input wire logic [sar_adc_pkg::DATA_W-1:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [sar_adc_pkg::DATA_W-1:0] read_data,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    input wire logic [3:0] timer_low_overflow,
    input wire logic [3:0] timer_high_overflow,
    input wire logic [3:0] timer_split_mode,
    input wire logic external_start_pin,
    input wire logic low_power_standby,
    input wire logic compare_above,
    input wire logic interrupt_enable,
    output logic converter_power,
    output logic track_enable,
    output logic [sar_adc_pkg::CODE_W-1:0] trial_code,
    output logic conversion_irq
);
    import sar_adc_pkg::*;

    // software-visible state
    logic converter_on; // enable bit
    logic low_power_track_select; // tracking-mode bit
    logic conversion_done_flag; // sticky done flag
    logic conversion_in_progress; // busy bit
    logic [2:0] start_source_select; // trigger choice
    logic [4:0] sar_clock_divider; // divider field
    logic left_align_select; // justification
    logic differential; // signed conversions
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;

    // sequencing state
    seq_state_t state;
    logic [1:0] track_count; // sar ticks spent tracking
    logic [3:0] bit_index; // bit under trial
    logic [7:0] spacing_count; // clocks since last start, saturating
    logic busy_last; // busy one cycle ago, for the falling edge
    logic pin_meta; // first synchroniser stage, read only by pin_sync
    logic pin_sync;
    logic pin_last;
    logic sar_tick;
    logic [3:0] timer_event; // timers 2..5 after mode selection
    logic pin_rise;
    logic source_event;
    logic software_start;
    logic start;
    logic direct_convert;
    logic finishing;
    logic [9:0] final_code;
    logic [7:0] packed_high;
    logic [7:0] packed_low;
    logic control_write;
    logic done_clear;

    // external pin passes two flops before any logic looks at it
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_last <= 1'b0;
        end
        else
        begin
            pin_meta <= external_start_pin;
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign pin_rise = pin_sync && !pin_last;

    // each of timers 2..5 uses its low-byte overflow when split into 8-bit halves
    genvar t;
    generate
        for (t = 0; t < 4; t++)
        begin : g_timer_pick
            assign timer_event[t] = timer_split_mode[t] ? timer_low_overflow[t] : timer_high_overflow[t];
        end
    endgenerate

    // trigger selection
    always_comb
    begin
        unique case (start_source_t'(start_source_select))
            SRC_SOFTWARE: source_event = 1'b0;
            SRC_TIMER0: source_event = timer0_overflow;
            SRC_TIMER2: source_event = timer_event[0];
            SRC_TIMER1: source_event = timer1_overflow;
            SRC_EXT_PIN: source_event = pin_rise;
            SRC_TIMER3: source_event = timer_event[1];
            SRC_TIMER4: source_event = timer_event[2];
            SRC_TIMER5: source_event = timer_event[3];
        endcase
    end

    assign control_write = write_strobe && (address == CONTROL_ADDR);
    // a software start needs the busy bit written as one with software source selected
    assign software_start = control_write && write_data[BUSY_BIT]
        && (write_data[SRC_LSB +: SRC_W] == SRC_SOFTWARE) && write_data[ON_BIT];
    // triggers that land while busy or too soon after the last start are dropped
    assign start = converter_on && (state == ST_IDLE) && (spacing_count == SPACING_LAST)
        && (software_start || source_event);
    // pin trigger in low-power mode has already tracked while the pin was low
    assign direct_convert = !low_power_track_select
        || (start_source_select == SRC_EXT_PIN && !software_start);
    assign finishing = (state == ST_CONVERT) && sar_tick && (bit_index == 4'h0);
    assign done_clear = control_write && !write_data[DONE_BIT];

    // last decision folded into the trial code
    always_comb
    begin
        final_code = trial_code;
        final_code[0] = compare_above;
    end

    sar_tick_gen u_tick
    (
        .clock(clock),
        .rst_n(rst_n),
        .run(state != ST_IDLE),
        .divider(sar_clock_divider),
        .tick(sar_tick)
    );

    result_packer u_pack
    (
        .code(final_code),
        .left_align_select(left_align_select),
        .differential(differential),
        .high_byte(packed_high),
        .low_byte(packed_low)
    );

    // control register fields owned by software
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            converter_on <= CONTROL_RESET[ON_BIT];
            low_power_track_select <= CONTROL_RESET[TRACK_MODE_BIT];
            start_source_select <= CONTROL_RESET[SRC_LSB +: SRC_W];
        end
        else if (control_write)
        begin
            converter_on <= write_data[ON_BIT];
            low_power_track_select <= write_data[TRACK_MODE_BIT];
            start_source_select <= write_data[SRC_LSB +: SRC_W];
        end
    end

    // configuration register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sar_clock_divider <= DIV_RESET;
            left_align_select <= 1'b0;
            differential <= 1'b0;
        end
        else if (write_strobe && address == CONFIG_ADDR)
        begin
            sar_clock_divider <= write_data[DIV_LSB +: DIV_W];
            left_align_select <= write_data[LEFT_BIT];
            differential <= write_data[DIFF_BIT];
        end
    end

    // sequencer: idle, optional tracking window, then ten bit trials
    always_ff @(posedge clock)
    begin
        if (!rst_n || !converter_on)
        begin
            state <= ST_IDLE;
            track_count <= 2'h0;
            bit_index <= CODE_TOP_INDEX;
            trial_code <= 10'h000;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state <= direct_convert ? ST_CONVERT : ST_TRACK;
                        track_count <= 2'h0;
                        bit_index <= CODE_TOP_INDEX;
                        trial_code <= CODE_MSB_ONLY;
                    end
                end
                ST_TRACK:
                begin
                    if (sar_tick)
                    begin
                        track_count <= track_count + 2'h1;
                        if (track_count == TRACK_TICKS - 2'h1)
                            state <= ST_CONVERT;
                    end
                end
                ST_CONVERT:
                begin
                    if (sar_tick)
                    begin
                        // keep the trial bit only if the input sits above it
                        trial_code[bit_index] <= compare_above;
                        if (bit_index == 4'h0)
                            state <= ST_IDLE;
                        else
                        begin
                            trial_code[bit_index - 4'h1] <= 1'b1;
                            bit_index <= bit_index - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // busy bit follows the sequencer, from the start until the last trial
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            conversion_in_progress <= 1'b0;
            busy_last <= 1'b0;
        end
        else
        begin
            busy_last <= conversion_in_progress;
            if (start)
                conversion_in_progress <= 1'b1;
            else if (finishing || !converter_on)
                conversion_in_progress <= 1'b0;
        end
    end

    // done flag: a falling busy edge wins over a software clear in the same cycle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            conversion_done_flag <= 1'b0;
        else if (busy_last && !conversion_in_progress)
            conversion_done_flag <= 1'b1;
        else if (done_clear)
            conversion_done_flag <= 1'b0;
    end

    // interrupt request mirrors the flag while the converter interrupt is enabled
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            conversion_irq <= 1'b0;
        else
            conversion_irq <= conversion_done_flag && interrupt_enable;
    end

    // result bytes latch the packed code as the last trial resolves
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end
        else if (finishing)
        begin
            result_high_byte <= packed_high;
            result_low_byte <= packed_low;
        end
    end

    // spacing counter keeps the start rate under the throughput ceiling
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            spacing_count <= SPACING_LAST;
        else if (start)
            spacing_count <= 8'h00;
        else if (spacing_count != SPACING_LAST)
            spacing_count <= spacing_count + 8'h01;
    end

    // analog controls: power, and when the sampling switch is closed
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            converter_power <= 1'b0;
            track_enable <= 1'b0;
        end
        else
        begin
            converter_power <= converter_on;
            if (!converter_on || low_power_standby)
                track_enable <= 1'b0;
            else if (!low_power_track_select)
                track_enable <= (state != ST_CONVERT);
            else if (start_source_select == SRC_EXT_PIN)
                track_enable <= (state == ST_IDLE) && !pin_sync;
            else
                track_enable <= (state == ST_TRACK);
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            read_data <= 8'h00;
        else if (read_strobe)
        begin
            unique case (address)
                CONTROL_ADDR: read_data <= {converter_on, low_power_track_select, conversion_done_flag,
                    conversion_in_progress, 1'b0, start_source_select};
                CONFIG_ADDR: read_data <= {sar_clock_divider, left_align_select, 1'b0, differential};
                RESULT_HIGH_ADDR: read_data <= result_high_byte;
                RESULT_LOW_ADDR: read_data <= result_low_byte;
                default: read_data <= UNMAPPED_READ;
            endcase
        end
        else
            read_data <= 8'h00;
    end

    // checks
    a_off_stays_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !converter_on |=> (state == ST_IDLE) && !track_enable)
        else $error("converter active while disabled");
    a_busy_sets_done: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(conversion_in_progress) |=> conversion_done_flag)
        else $error("done flag missed busy fall");
    a_result_loaded: assert property (@(posedge clock) disable iff (!rst_n)
        finishing |=> (result_low_byte == $past(packed_low)) && (result_high_byte == $past(packed_high)))
        else $error("result not loaded at end");
    a_busy_through_run: assert property (@(posedge clock) disable iff (!rst_n)
        (state != ST_IDLE) |-> conversion_in_progress)
        else $error("busy low during conversion");
    a_sw_start_busy: assert property (@(posedge clock) disable iff (!rst_n)
        (software_start && converter_on && state == ST_IDLE && spacing_count == SPACING_LAST)
        |=> conversion_in_progress && state != ST_IDLE)
        else $error("software start ignored");
    a_lp_track_three: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_IDLE && start && !direct_convert) |=> (state == ST_TRACK) [*3])
        else $error("tracking window too short");
    a_start_spacing: assert property (@(posedge clock) disable iff (!rst_n)
        start |=> !start [*8])
        else $error("starts too close together");
    a_left_zero_low: assert property (@(posedge clock) disable iff (!rst_n)
        (finishing && left_align_select) |=> result_low_byte[5:0] == 6'h00)
        else $error("unused low bits not zero");
    a_right_single: assert property (@(posedge clock) disable iff (!rst_n)
        (finishing && !left_align_select && !differential) |=> result_high_byte[7:2] == 6'h00)
        else $error("unused high bits not zero");
    a_standby_no_track: assert property (@(posedge clock) disable iff (!rst_n)
        low_power_standby |=> !track_enable)
        else $error("tracking during standby");
endmodule
`default_nettype wire

//--- core/sar_tick_gen.sv
`default_nettype none
// one-cycle tick every (divider + 1) system clocks while run is high
module sar_tick_gen
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [4:0] divider,
    output logic tick
);
    import sar_adc_pkg::*;

    logic [4:0] count; // system clocks since last tick

    // counter restarts whenever run drops, so the first tick is a full period away
    always_ff @(posedge clock)
    begin
        if (!rst_n || !run)
        begin
            count <= 5'h00;
            tick <= 1'b0;
        end
        else if (count >= divider)
        begin
            count <= 5'h00;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 5'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- sim/analog_input_model.sv
`default_nettype none
// stands in for the sampling array and its comparator
// the held input is compared with the trial code in the same cycle, as the real comparator settles
// within one system clock; a slower comparator would need a pipeline stage here
module analog_input_model
(
    input wire logic [9:0] trial_code,
    input wire logic [9:0] input_level,
    output logic compare_above
);
    // offset-binary compare, so differential inputs need no special case on this side
    always_comb
    begin
        compare_above = (input_level >= trial_code);
    end
endmodule
`default_nettype wire

//--- sim/sar_adc_sequencer_test.sv
`default_nettype none
module sar_adc_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_adc_pkg::*;
    logic clock = 1'b0; // 125 MHz system clock
    logic rst_n = 1'b0; // synchronous, active low
    logic [3:0] address = 4'h0;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [7:0] read_data;
    logic timer0_overflow = 1'b0;
    logic timer1_overflow = 1'b0;
    logic [3:0] timer_low_overflow = 4'h0;
    logic [3:0] timer_high_overflow = 4'h0;
    logic [3:0] timer_split_mode = 4'h5; // timers 2 and 4 in 8-bit mode, 3 and 5 in 16-bit mode
    logic external_start_pin = 1'b0;
    logic low_power_standby = 1'b0;
    logic compare_above;
    logic interrupt_enable = 1'b1;
    logic converter_power;
    logic track_enable;
    logic [9:0] trial_code;
    logic conversion_irq;
    logic [9:0] input_level = 10'h000; // analog value the model holds
    logic [9:0] levels [4] = '{10'h3FF, 10'h200, 10'h100, 10'h000};
    logic [7:0] d;
    logic [15:0] word;
    int n_mismatch = 0;
    int num_checks = 0;
    int t0;
    int t1;
    int t2;
    int k;

    // free-running clock, 8 ns period
    always #4 clock = ~clock;

    sar_adc_sequencer u_sar_adc_sequencer (.clock(clock), .rst_n(rst_n), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data(read_data), .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
        .timer_low_overflow(timer_low_overflow), .timer_high_overflow(timer_high_overflow),
        .timer_split_mode(timer_split_mode), .external_start_pin(external_start_pin),
        .low_power_standby(low_power_standby), .compare_above(compare_above),
        .interrupt_enable(interrupt_enable), .converter_power(converter_power),
        .track_enable(track_enable), .trial_code(trial_code), .conversion_irq(conversion_irq));

    analog_input_model u_analog_input_model (.trial_code(trial_code), .input_level(input_level),
        .compare_above(compare_above));

    // verdict and the only place the run ends
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // four-state compare, so an unknown never passes
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        address <= a;
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // one-cycle read strobe, data stands only in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        v = read_data;
    endtask

    // counts cycles until the request rises, bounded
    task automatic wait_irq(output int cyc);
        cyc = 0;
        while (conversion_irq !== 1'b1)
        begin
            @(posedge clock);
            #1;
            cyc++;
            if (cyc > 3000)
            begin
                n_mismatch++;
                $display("Error conversion_irq expected 1 seen %b", conversion_irq);
                stop_test();
            end
        end
    endtask

    // firmware acknowledges by writing the done bit to 0; busy left 0 so nothing restarts
    task automatic clear_done(input logic [7:0] ctrl);
        wr(CONTROL_ADDR, ctrl & 8'hC7);
        repeat (2) @(posedge clock);
        #1;
        check("irq after clear", 16'(conversion_irq), 16'h0000);
        check("idle tracking", 16'(track_enable), 16'(!ctrl[TRACK_MODE_BIT]));
    endtask

    // software-started conversion; waits out the start spacing first
    task automatic sw_convert(input logic [7:0] ctrl, output int cyc, output logic [15:0] w);
        logic [7:0] v;
        logic [7:0] h;
        repeat (250) @(posedge clock);
        wr(CONTROL_ADDR, ctrl);
        wr(CONTROL_ADDR, ctrl | 8'h10);
        rd(CONTROL_ADDR, v);
        check("busy during conversion", 16'(v[BUSY_BIT]), 16'h0001);
        check("tracking during conversion", 16'(track_enable), 16'(ctrl[TRACK_MODE_BIT]));
        wait_irq(cyc);
        rd(CONTROL_ADDR, v);
        check("done and busy", 16'({v[DONE_BIT], v[BUSY_BIT]}), 16'h0002);
        rd(RESULT_HIGH_ADDR, h);
        rd(RESULT_LOW_ADDR, v);
        w = {h, v};
        clear_done(ctrl);
    endtask

    // expected word from the code layout: zero fill, sign fill, or left aligned
    function automatic logic [15:0] expect_word(input logic [9:0] lvl, input logic left, input logic diff);
        logic [9:0] c;
        c = diff ? (lvl ^ CODE_MSB_ONLY) : lvl;
        if (left)
            return {c, 6'h00};
        return diff ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction

    // trigger bit for a source: [0] timer0 [1] timer1 [5:2] low overflow [9:6] high overflow [10] pin
    function automatic logic [10:0] trig_mask(input int s);
        int t;
        t = (s == 2) ? 0 : s - 4;
        case (s)
            1: return 11'h001;
            3: return 11'h002;
            4: return 11'h400;
            default: return timer_split_mode[t] ? (11'h004 << t) : (11'h040 << t);
        endcase
    endfunction

    // one-cycle pulses on the chosen trigger inputs; the pin gives one rising edge
    task automatic pulse(input logic [10:0] m);
        @(posedge clock);
        timer0_overflow <= m[0];
        timer1_overflow <= m[1];
        timer_low_overflow <= m[5:2];
        timer_high_overflow <= m[9:6];
        external_start_pin <= m[10];
        @(posedge clock);
        {timer0_overflow, timer1_overflow, timer_low_overflow, timer_high_overflow, external_start_pin} <= 11'h000;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        // values after reset, and an unmapped address
        rd(CONTROL_ADDR, d);
        check("control reset", 16'(d), 16'(CONTROL_RESET));
        rd(CONFIG_ADDR, d);
        check("config reset", 16'(d), 16'({DIV_RESET, 3'h0}));
        rd(RESULT_HIGH_ADDR, d);
        check("result high reset", 16'(d), 16'h0000);
        rd(RESULT_LOW_ADDR, d);
        check("result low reset", 16'(d), 16'h0000);
        rd(4'hF, d);
        check("unmapped read", 16'(d), 16'(UNMAPPED_READ));
        check("power while off", 16'(converter_power), 16'h0000);
        wr(CONFIG_ADDR, 8'h00);
        wr(CONTROL_ADDR, 8'h80);
        @(posedge clock);
        #1;
        check("power when on", 16'(converter_power), 16'h0001);
        check("default tracking", 16'(track_enable), 16'h0001);
        // standby shuts the sampling switch
        @(posedge clock);
        low_power_standby <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("standby tracking", 16'(track_enable), 16'h0000);
        @(posedge clock);
        low_power_standby <= 1'b0;
        // every layout of every sample level
        for (int df = 0; df < 2; df++)
            for (int lf = 0; lf < 2; lf++)
                for (int i = 0; i < 4; i++)
                begin
                    wr(CONFIG_ADDR, {5'h00, lf[0], 1'b0, df[0]});
                    @(posedge clock);
                    input_level <= levels[i];
                    sw_convert(8'h80, k, word);
                    check("result word", word, expect_word(levels[i], lf[0], df[0]));
                end
        // conversion length against divider and tracking mode
        wr(CONFIG_ADDR, 8'h00);
        sw_convert(8'h80, t0, word);
        wr(CONFIG_ADDR, 8'h08);
        sw_convert(8'h80, t1, word);
        sw_convert(8'hC0, t2, word);
        check("divider step", 16'(t1 - t0), 16'h000A);
        check("track period", 16'(t2 - t1), 16'h0006);
        check("low-power word", word, expect_word(input_level, 1'b0, 1'b0));
        // a second start too soon after the last one is dropped
        wr(CONFIG_ADDR, 8'h00);
        sw_convert(8'h80, k, word);
        wr(CONTROL_ADDR, 8'h90);
        repeat (30) @(posedge clock);
        #1;
        check("early start dropped", 16'(conversion_irq), 16'h0000);
        // masked request: firmware polls the done flag instead
        repeat (250) @(posedge clock);
        interrupt_enable <= 1'b0;
        wr(CONTROL_ADDR, 8'h90);
        d = 8'h00;
        k = 0;
        while (d[DONE_BIT] !== 1'b1 && k < 100)
        begin
            rd(CONTROL_ADDR, d);
            k++;
        end
        check("polled done", 16'(d[DONE_BIT]), 16'h0001);
        check("masked irq", 16'(conversion_irq), 16'h0000);
        @(posedge clock);
        interrupt_enable <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("unmasked irq", 16'(conversion_irq), 16'h0001);
        clear_done(8'h80);
        // each hardware source, with every other trigger offered first as a decoy
        for (int s = 1; s < 8; s++)
        begin
            wr(CONTROL_ADDR, 8'h80 | 8'(s) | (s == 4 ? 8'h40 : 8'h00));
            repeat (250) @(posedge clock);
            pulse(~trig_mask(s));
            repeat (20) @(posedge clock);
            #1;
            check("decoy triggers", 16'(conversion_irq), 16'h0000);
            check("pin low tracking", 16'(track_enable), 16'h0001);
            pulse(trig_mask(s));
            wait_irq(k);
            clear_done(8'h80 | 8'(s));
        end
        // disabled converter ignores a software start
        repeat (250) @(posedge clock);
        wr(CONTROL_ADDR, 8'h10);
        repeat (30) @(posedge clock);
        #1;
        check("disabled irq", 16'(conversion_irq), 16'h0000);
        check("disabled power", 16'(converter_power), 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
